// [rtl/aipk_packer.sv]
// What this block does
// - Device type: profile 5001 low, module profile high.
// - Revision word: special number low, description high.
// - Serial: year, week, upper half zero.
// - Read-only maker and product identification words.
// - Read-only checksum over all backup entries.
// - A channel's full and value layouts never sent together.
// - Full layout: under, over, limit1, limit2, error.
// - Seven filler bits after error flag.
// - Then validity, toggle, 16-bit sample; nine entries.
// - Value layout holds only the sample.
// - Limit code: off, below, above, equal.
// - Toggle inverts per refresh; validity high invalid.
// - Error set when sample out of range.
`include "aipk_regs.svh"

module aipk_packer
   import aipk_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int SAMPLE_W = 16,
   parameter int FIFO_DEPTH = 16,
   parameter int NUM_BACKUP = 4,
   parameter logic [15:0] MODULE_PROFILE = 16'h0000, // Arbitrary value.
   parameter logic [31:0] MAKER_ID = 32'h0000_0A5A, // Arbitrary value.
   parameter logic [31:0] PRODUCT_ID = 32'h0000_1234, // Arbitrary value.
   parameter logic [15:0] SPECIAL_NUM = 16'h0000, // Arbitrary value.
   parameter logic [15:0] DESC_REV = 16'h0001, // Arbitrary value.
   parameter logic [7:0] PROD_YEAR = 8'h18, // Arbitrary value.
   parameter logic [7:0] PROD_WEEK = 8'h01 // Arbitrary value.
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_CH-1:0] sample_strobe,
   input wire logic [NUM_CH*SAMPLE_W-1:0] sample_value,
   input wire logic [NUM_CH-1:0] below_range,
   input wire logic [NUM_CH-1:0] above_range,
   input wire logic [NUM_CH*2-1:0] limit1_code,
   input wire logic [NUM_CH*2-1:0] limit2_code,
   input wire logic [NUM_CH-1:0] sample_invalid,
   input wire logic [NUM_CH-1:0] full_select,
   input wire logic [NUM_CH-1:0] value_select,
   output logic [NUM_CH-1:0] layout_conflict,
   input wire logic image_start,
   output logic image_busy,
   output logic img_valid,
   input wire logic img_ready,
   output logic [SAMPLE_W-1:0] img_data,
   output logic img_last,
   input wire logic [NUM_BACKUP*32-1:0] backup_entries,
   input wire logic obj_req,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_subindex,
   output logic obj_ack,
   output logic obj_error,
   output logic [31:0] obj_data
);
   localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam int FW = SAMPLE_W + 16;
   localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);

   logic [FW-1:0] full_word [NUM_CH];
   logic [FW-1:0] snap [NUM_CH];
   logic [FW-1:0] next_snap [NUM_CH];
   logic [NUM_CH-1:0] use_full;
   logic [NUM_CH-1:0] use_value;
   logic [NUM_CH-1:0] next_use_full;
   logic [NUM_CH-1:0] next_use_value;
   aipk_state_t state;
   aipk_state_t next_state;
   logic [CH_W-1:0] ch;
   logic [CH_W-1:0] next_ch;
   logic half;
   logic next_half;
   logic push;
   logic push_ready;
   logic [SAMPLE_W:0] push_data;
   logic [SAMPLE_W:0] pop_data;
   logic [31:0] checksum;
   logic [31:0] next_checksum;
   logic next_obj_ack;
   logic next_obj_error;
   logic [31:0] next_obj_data;

   // True when any channel above the given one is selected.
   function automatic logic more_after(input logic [NUM_CH-1:0] sel, input logic [CH_W-1:0] c);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (i > int'(c) && sel[i]) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction : more_after

   // Mapping entry word of a layout object: input index, subindex, bit length.
   function automatic logic [31:0] map_entry(input logic [3:0] n, input logic [7:0] sub);
      logic [15:0] idx;
      logic [31:0] r;
      idx = {`AIPK_INPUTS_BASE, 1'b0, n[3:1], 4'h0};
      r = 32'h0000_0000;
      if (n[0]) begin
         if (sub == 8'h01) begin
            r = {idx, `AIPK_E_VALUE, 8'h10};
         end
      end else begin
         case (sub)
            8'h01: r = {idx, `AIPK_E_UNDER, 8'h01};
            8'h02: r = {idx, `AIPK_E_OVER, 8'h01};
            8'h03: r = {idx, `AIPK_E_LIMIT1, 8'h02};
            8'h04: r = {idx, `AIPK_E_LIMIT2, 8'h02};
            8'h05: r = {idx, `AIPK_E_ERROR, 8'h01};
            8'h06: r = {16'h0000, 8'h00, `AIPK_LEN_FILL};
            8'h07: r = {idx, `AIPK_E_VALID, 8'h01};
            8'h08: r = {idx, `AIPK_E_TOGGLE, 8'h01};
            8'h09: r = {idx, `AIPK_E_VALUE, 8'h10};
            default: r = 32'h0000_0000;
         endcase
      end
      return r;
   endfunction : map_entry

   // True when a layout object number belongs to an existing channel.
   function automatic logic obj_in_range(input logic [3:0] n);
      return int'(n) < 2 * NUM_CH;
   endfunction : obj_in_range

   // One capture and layout former per channel.
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         aipk_channel #(
            .SAMPLE_W(SAMPLE_W)
         ) u_ch (
            .clk(clk),
            .rst_n(rst_n),
            .sample_strobe(sample_strobe[g]),
            .sample_value(sample_value[g*SAMPLE_W +: SAMPLE_W]),
            .below_range(below_range[g]),
            .above_range(above_range[g]),
            .limit1_code(aipk_limit_t'(limit1_code[g*2 +: 2])),
            .limit2_code(aipk_limit_t'(limit2_code[g*2 +: 2])),
            .sample_invalid(sample_invalid[g]),
            .full_word(full_word[g])
         );
      end
   endgenerate

   // A channel asking for both layouts gets the full one only.
   assign layout_conflict = full_select & value_select;

   // Image walker: snapshot at start, then emit selected words channel by channel.
   always_comb begin
      next_state = state;
      next_ch = ch;
      next_half = half;
      next_use_full = use_full;
      next_use_value = use_value;
      next_snap = snap;
      push = 1'b0;
      push_data = '0;
      case (state)
         AIPK_IDLE: begin
            if (image_start) begin
               next_snap = full_word;
               next_use_full = full_select;
               next_use_value = value_select & ~full_select;
               next_ch = '0;
               next_half = 1'b0;
               next_state = AIPK_EMIT;
            end
         end
         AIPK_EMIT: begin
            if (!use_full[ch] && !use_value[ch]) begin
               if (ch == LAST_CH) begin
                  next_state = AIPK_IDLE;
               end else begin
                  next_ch = ch + 1'b1;
               end
            end else begin
               push = 1'b1;
               if (use_full[ch]) begin
                  push_data[SAMPLE_W-1:0] = half ? snap[ch][FW-1:16] : snap[ch][15:0];
                  push_data[SAMPLE_W] = half && !more_after(use_full | use_value, ch);
               end else begin
                  push_data[SAMPLE_W-1:0] = snap[ch][`AIPK_F_VALUE +: SAMPLE_W];
                  push_data[SAMPLE_W] = !more_after(use_full | use_value, ch);
               end
               if (push_ready) begin
                  if (use_full[ch] && !half) begin
                     next_half = 1'b1;
                  end else begin
                     next_half = 1'b0;
                     if (ch == LAST_CH) begin
                        next_state = AIPK_IDLE;
                     end else begin
                        next_ch = ch + 1'b1;
                     end
                  end
               end
            end
         end
         default: next_state = AIPK_IDLE;
      endcase
   end

   // Walker registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= AIPK_IDLE;
         ch <= '0;
         half <= 1'b0;
         use_full <= '0;
         use_value <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            snap[i] <= '0;
         end
      end else begin
         state <= next_state;
         ch <= next_ch;
         half <= next_half;
         use_full <= next_use_full;
         use_value <= next_use_value;
         snap <= next_snap;
      end
   end

   assign image_busy = (state == AIPK_EMIT);

   // Output buffer; a stalled reader holds the walker.
   aipk_fifo #(
      .WIDTH(SAMPLE_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(img_valid),
      .out_ready(img_ready),
      .out_data(pop_data)
   );

   assign img_data = pop_data[SAMPLE_W-1:0];
   assign img_last = pop_data[SAMPLE_W];

   // Checksum is the running word sum of all backup entries.
   always_comb begin
      next_checksum = 32'h0000_0000;
      for (int i = 0; i < NUM_BACKUP; i++) begin
         next_checksum = next_checksum + backup_entries[i*32 +: 32];
      end
   end

   // Object read decode; unknown objects answer with an error flag and zero data.
   always_comb begin
      next_obj_ack = obj_req;
      next_obj_error = 1'b0;
      next_obj_data = 32'h0000_0000;
      if (obj_req) begin
         if (obj_index == `AIPK_IDX_DEVICE_TYPE && obj_subindex == `AIPK_SUB_COUNT) begin
            next_obj_data = {MODULE_PROFILE, `AIPK_PROFILE_NUM};
         end else if (obj_index == `AIPK_IDX_IDENTITY) begin
            case (obj_subindex)
               `AIPK_SUB_COUNT: next_obj_data = `AIPK_IDENTITY_COUNT;
               `AIPK_SUB_MAKER: next_obj_data = MAKER_ID;
               `AIPK_SUB_PRODUCT: next_obj_data = PRODUCT_ID;
               `AIPK_SUB_REVISION: next_obj_data = {DESC_REV, SPECIAL_NUM};
               `AIPK_SUB_SERIAL: next_obj_data = {16'h0000, PROD_WEEK, PROD_YEAR};
               default: next_obj_error = 1'b1;
            endcase
         end else if (obj_index == `AIPK_IDX_BACKUP) begin
            case (obj_subindex)
               `AIPK_SUB_COUNT: next_obj_data = `AIPK_BACKUP_COUNT;
               `AIPK_SUB_CHECKSUM: next_obj_data = checksum;
               default: next_obj_error = 1'b1;
            endcase
         end else if (obj_index[15:4] == `AIPK_PDO_PAR_BASE && obj_in_range(obj_index[3:0])) begin
            case (obj_subindex)
               `AIPK_SUB_COUNT: next_obj_data = `AIPK_PDO_PAR_COUNT;
               `AIPK_SUB_EXCLUDE: next_obj_data = {16'h0000, 4'h0, obj_index[3:1], !obj_index[0],
                                                   8'(`AIPK_PDO_MAP_BASE >> 4)};
               default: next_obj_error = 1'b1;
            endcase
         end else if (obj_index[15:4] == `AIPK_PDO_MAP_BASE && obj_in_range(obj_index[3:0])) begin
            if (obj_subindex == `AIPK_SUB_COUNT) begin
               next_obj_data = obj_index[0] ? `AIPK_VALUE_MAP_COUNT : `AIPK_FULL_MAP_COUNT;
            end else if (map_entry(obj_index[3:0], obj_subindex) != 32'h0000_0000) begin
               next_obj_data = map_entry(obj_index[3:0], obj_subindex);
            end else begin
               next_obj_error = 1'b1;
            end
         end else begin
            next_obj_error = 1'b1;
         end
      end
   end

   // Object answer and checksum registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         obj_ack <= 1'b0;
         obj_error <= 1'b0;
         obj_data <= 32'h0000_0000;
         checksum <= 32'h0000_0000;
      end else begin
         obj_ack <= next_obj_ack;
         obj_error <= next_obj_error;
         obj_data <= next_obj_data;
         checksum <= next_checksum;
      end
   end
endmodule : aipk_packer

// [rtl/aipk_regs.svh]
`ifndef AIPK_REGS_SVH
`define AIPK_REGS_SVH

// Object indices that the master reads.
`define AIPK_IDX_DEVICE_TYPE 16'h1000
`define AIPK_IDX_IDENTITY 16'h1018
`define AIPK_IDX_BACKUP 16'h10F0
`define AIPK_PDO_PAR_BASE 12'h180
`define AIPK_PDO_MAP_BASE 12'h1A0
`define AIPK_INPUTS_BASE 8'h60

// Subindices.
`define AIPK_SUB_COUNT 8'h00
`define AIPK_SUB_MAKER 8'h01
`define AIPK_SUB_PRODUCT 8'h02
`define AIPK_SUB_REVISION 8'h03
`define AIPK_SUB_SERIAL 8'h04
`define AIPK_SUB_CHECKSUM 8'h01
`define AIPK_SUB_EXCLUDE 8'h06

// Fixed object values.
`define AIPK_PROFILE_NUM 16'h1389
`define AIPK_IDENTITY_COUNT 32'h0000_0002
`define AIPK_BACKUP_COUNT 32'h0000_0001
`define AIPK_PDO_PAR_COUNT 32'h0000_0006
`define AIPK_FULL_MAP_COUNT 32'h0000_0009
`define AIPK_VALUE_MAP_COUNT 32'h0000_0001

// Full layout field positions, least significant bit first.
`define AIPK_F_UNDER 0
`define AIPK_F_OVER 1
`define AIPK_F_LIMIT1 2
`define AIPK_F_LIMIT2 4
`define AIPK_F_ERROR 6
`define AIPK_F_FILL 7
`define AIPK_F_VALID 14
`define AIPK_F_TOGGLE 15
`define AIPK_F_VALUE 16

// Input object subindices of the mapped entries, and the filler bit length.
`define AIPK_E_UNDER 8'h01
`define AIPK_E_OVER 8'h02
`define AIPK_E_LIMIT1 8'h03
`define AIPK_E_LIMIT2 8'h05
`define AIPK_E_ERROR 8'h07
`define AIPK_E_VALID 8'h0F
`define AIPK_E_TOGGLE 8'h10
`define AIPK_E_VALUE 8'h11
`define AIPK_LEN_FILL 8'h07

`endif

// [rtl/aipk_pkg.sv]
package aipk_pkg;

   // Limit monitor codes reported by the conversion.
   typedef enum logic [1:0] {
      AIPK_LIMIT_OFF = 2'h0,
      AIPK_LIMIT_BELOW = 2'h1,
      AIPK_LIMIT_ABOVE = 2'h2,
      AIPK_LIMIT_EQUAL = 2'h3
   } aipk_limit_t;

   // Image walker states.
   typedef enum logic [1:0] {
      AIPK_IDLE,
      AIPK_EMIT
   } aipk_state_t;

endpackage : aipk_pkg

// [rtl/aipk_fifo.sv]
module aipk_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push;
   logic pop;

   // Full when the pointers differ only in the wrap bit, empty when equal.
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer advance.
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   // Pointer registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage is written only; it needs no reset.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule : aipk_fifo

// [rtl/aipk_channel.sv]
`include "aipk_regs.svh"

module aipk_channel
   import aipk_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_strobe,
   input wire logic [SAMPLE_W-1:0] sample_value,
   input wire logic below_range,
   input wire logic above_range,
   input wire aipk_limit_t limit1_code,
   input wire aipk_limit_t limit2_code,
   input wire logic sample_invalid,
   output logic [SAMPLE_W+15:0] full_word
);
   logic under_q;
   logic over_q;
   aipk_limit_t lim1_q;
   aipk_limit_t lim2_q;
   logic error_q;
   logic invalid_q;
   logic toggle_q;
   logic [SAMPLE_W-1:0] value_q;
   logic next_under;
   logic next_over;
   aipk_limit_t next_lim1;
   aipk_limit_t next_lim2;
   logic next_error;
   logic next_invalid;
   logic next_toggle;
   logic [SAMPLE_W-1:0] next_value;

   // Capture a refreshed sample and its flags on each strobe.
   always_comb begin
      next_under = under_q;
      next_over = over_q;
      next_lim1 = lim1_q;
      next_lim2 = lim2_q;
      next_error = error_q;
      next_invalid = invalid_q;
      next_toggle = toggle_q;
      next_value = value_q;
      if (sample_strobe) begin
         next_under = below_range;
         next_over = above_range;
         next_lim1 = limit1_code;
         next_lim2 = limit2_code;
         next_error = below_range || above_range;
         next_invalid = sample_invalid || below_range || above_range;
         next_toggle = !toggle_q;
         next_value = sample_value;
      end
   end

   // Channel state registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         under_q <= 1'b0;
         over_q <= 1'b0;
         lim1_q <= AIPK_LIMIT_OFF;
         lim2_q <= AIPK_LIMIT_OFF;
         error_q <= 1'b0;
         invalid_q <= 1'b0;
         toggle_q <= 1'b0;
         value_q <= '0;
      end else begin
         under_q <= next_under;
         over_q <= next_over;
         lim1_q <= next_lim1;
         lim2_q <= next_lim2;
         error_q <= next_error;
         invalid_q <= next_invalid;
         toggle_q <= next_toggle;
         value_q <= next_value;
      end
   end

   // Full layout, least significant bit first.
   always_comb begin
      full_word = '0;
      full_word[`AIPK_F_UNDER] = under_q;
      full_word[`AIPK_F_OVER] = over_q;
      full_word[`AIPK_F_LIMIT1 +: 2] = lim1_q;
      full_word[`AIPK_F_LIMIT2 +: 2] = lim2_q;
      full_word[`AIPK_F_ERROR] = error_q;
      full_word[`AIPK_F_FILL +: 7] = 7'h00;
      full_word[`AIPK_F_VALID] = invalid_q;
      full_word[`AIPK_F_TOGGLE] = toggle_q;
      full_word[`AIPK_F_VALUE +: SAMPLE_W] = value_q;
   end
endmodule : aipk_channel

// [verif/aipk_packer_monitor.sv]
module aipk_packer_monitor #(
   parameter int NUM_CH = 4,
   parameter int SAMPLE_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_CH-1:0] full_select,
   input wire logic [NUM_CH-1:0] value_select,
   input wire logic [NUM_CH-1:0] layout_conflict,
   input wire logic image_start,
   input wire logic image_busy,
   input wire logic img_valid,
   input wire logic img_ready,
   input wire logic [SAMPLE_W-1:0] img_data,
   input wire logic img_last,
   input wire logic obj_req,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_subindex,
   input wire logic obj_ack,
   input wire logic obj_error,
   input wire logic [31:0] obj_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // All checks run on the device clock and sleep during reset.
   default clocking mon_clk @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Object answers come exactly one cycle after the request and never otherwise.
   chk_ack_after_req: assert property (obj_req |=> obj_ack) else $error("ack missing after request");
   chk_ack_no_req: assert property (!obj_req |=> !obj_ack) else $error("ack without request");
   chk_error_data_zero: assert property (obj_ack && obj_error |-> obj_data == 32'h0000_0000)
      else $error("refused read carries data");
   // Fixed object values.
   chk_devtype_low: assert property (obj_req && obj_index == 16'h1000 && obj_subindex == 8'h00
      |=> !obj_error && obj_data[15:0] == 16'h1389) else $error("device type low word wrong");
   chk_serial_upper: assert property (obj_req && obj_index == 16'h1018 && obj_subindex == 8'h04
      |=> obj_data[31:16] == 16'h0000) else $error("serial upper half not zero");
   chk_full_count: assert property (obj_req && obj_index == 16'h1A00 && obj_subindex == 8'h00
      |=> obj_data == 32'h0000_0009) else $error("full layout entry count wrong");
   chk_value_count: assert property (obj_req && obj_index == 16'h1A01 && obj_subindex == 8'h00
      |=> obj_data == 32'h0000_0001) else $error("value layout entry count wrong");
   chk_exclude_list: assert property (obj_req && obj_index == 16'h1800 && obj_subindex == 8'h06
      |=> obj_data[15:0] == 16'h011A) else $error("exclusion list wrong");
   // Layout conflict and image stream handshake.
   chk_conflict_flag: assert property (layout_conflict == (full_select & value_select))
      else $error("layout conflict flag wrong");
   chk_word_holds: assert property (img_valid && !img_ready |=> img_valid && $stable(img_data)
      && $stable(img_last)) else $error("image word changed while stalled");
   chk_start_busy: assert property (image_start && !image_busy |=> image_busy [*2])
      else $error("image start not taken");
endmodule : aipk_packer_monitor

bind aipk_packer aipk_packer_monitor #(.NUM_CH(NUM_CH), .SAMPLE_W(SAMPLE_W)) u_monitor (
   .clk(clk), .rst_n(rst_n), .full_select(full_select), .value_select(value_select),
   .layout_conflict(layout_conflict), .image_start(image_start), .image_busy(image_busy),
   .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data), .img_last(img_last),
   .obj_req(obj_req), .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_ack(obj_ack),
   .obj_error(obj_error), .obj_data(obj_data)
);

// [verif/aipk_master_model.sv]
module aipk_master_model #(
   parameter int SAMPLE_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic slow,
   input wire logic img_valid,
   input wire logic [SAMPLE_W-1:0] img_data,
   input wire logic img_last,
   output logic img_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [SAMPLE_W:0] got[$];
   logic phase;

   // Ready drops while stalled and on every other cycle in slow mode.
   assign img_ready = !stall && !(slow && phase);

   // Words are taken only at an edge where valid and ready are both high.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 1'h0;
      end else begin
         phase <= !phase;
         if (img_valid && img_ready) begin
            got.push_back({img_last, img_data});
         end
      end
   end
endmodule : aipk_master_model

// [verif/aipk_packer_test.sv]
module aipk_packer_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [15:0] idx; logic [7:0] sub; logic [31:0] dat; logic err;} aipk_row_t;
   logic clk, rst_n, image_start, image_busy, img_valid, img_ready, img_last, stall, slow;
   logic obj_req, obj_ack, obj_error;
   logic [3:0] sample_strobe, below_range, above_range, sample_invalid, full_select, value_select;
   logic [3:0] layout_conflict, tog;
   logic [63:0] sample_value;
   logic [7:0] limit1_code, limit2_code, obj_subindex;
   logic [15:0] img_data, obj_index;
   logic [127:0] backup_entries;
   logic [31:0] obj_data, sum;
   logic [16:0] exp_q[$];
   int bad_count, cmp_count;
   aipk_row_t rows[21] = '{
      '{16'h1000, 8'h00, 32'h0000_1389, 1'h0},
      '{16'h1018, 8'h00, 32'h0000_0002, 1'h0}, '{16'h1018, 8'h01, 32'h0000_0A5A, 1'h0},
      '{16'h1018, 8'h02, 32'h0000_1234, 1'h0}, '{16'h1018, 8'h03, 32'h0001_0000, 1'h0},
      '{16'h1018, 8'h04, 32'h0000_0118, 1'h0}, '{16'h10F0, 8'h00, 32'h0000_0001, 1'h0},
      '{16'h1800, 8'h06, 32'h0000_011A, 1'h0}, '{16'h1801, 8'h06, 32'h0000_001A, 1'h0},
      '{16'h1A00, 8'h00, 32'h0000_0009, 1'h0}, '{16'h1A00, 8'h01, 32'h6000_0101, 1'h0},
      '{16'h1A00, 8'h03, 32'h6000_0302, 1'h0}, '{16'h1A02, 8'h04, 32'h6010_0502, 1'h0},
      '{16'h1A00, 8'h06, 32'h0000_0007, 1'h0}, '{16'h1A00, 8'h09, 32'h6000_1110, 1'h0},
      '{16'h1A01, 8'h00, 32'h0000_0001, 1'h0}, '{16'h1A01, 8'h01, 32'h6000_1110, 1'h0},
      '{16'h1800, 8'h00, 32'h0000_0006, 1'h0}, '{16'h1808, 8'h06, 32'h0000_0000, 1'h1},
      '{16'h2000, 8'h00, 32'h0000_0000, 1'h1}, '{16'h1018, 8'h05, 32'h0000_0000, 1'h1}};

   aipk_packer u_dut (.clk(clk), .rst_n(rst_n), .sample_strobe(sample_strobe), .sample_value(sample_value),
      .below_range(below_range), .above_range(above_range), .limit1_code(limit1_code),
      .limit2_code(limit2_code), .sample_invalid(sample_invalid), .full_select(full_select),
      .value_select(value_select), .layout_conflict(layout_conflict), .image_start(image_start),
      .image_busy(image_busy), .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data),
      .img_last(img_last), .backup_entries(backup_entries), .obj_req(obj_req), .obj_index(obj_index),
      .obj_subindex(obj_subindex), .obj_ack(obj_ack), .obj_error(obj_error), .obj_data(obj_data));

   aipk_master_model u_master (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow), .img_valid(img_valid),
      .img_data(img_data), .img_last(img_last), .img_ready(img_ready));

   // Free running 40 MHz clock.
   initial begin
      clk = 1'h0;
      forever #12.5 clk = !clk;
   end

   task automatic end_sim();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One object read; the answer is looked at in the cycle after the request.
   task automatic obj_read(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic err);
      @(negedge clk);
      obj_req = 1'h1;
      obj_index = idx;
      obj_subindex = sub;
      @(negedge clk);
      obj_req = 1'h0;
      check("obj_ack", 32'h0000_0001, {31'h0, obj_ack});
      check("obj_error", {31'h0, err}, {31'h0, obj_error});
      check("obj_data", exp, obj_data);
   endtask : obj_read

   task automatic wait_idle();
      int n;
      n = 0;
      while (image_busy !== 1'h0) begin
         @(negedge clk);
         n++;
         if (n > 300) begin
            bad_count++;
            $display("[ERR] image_busy expected 0 seen %b", image_busy);
            end_sim();
         end
      end
   endtask : wait_idle

   task automatic strobe_all();
      @(negedge clk);
      sample_strobe = 4'hF;
      tog = ~tog;
      @(negedge clk);
      sample_strobe = 4'h0;
   endtask : strobe_all

   // Queues the words that the current selects should yield, then starts the image.
   task automatic start_image();
      int first;
      logic bad;
      first = exp_q.size();
      for (int g = 0; g < 4; g++) begin
         bad = below_range[g] | above_range[g];
         if (full_select[g]) begin
            exp_q.push_back({1'h0, tog[g], bad | sample_invalid[g], 7'h00, bad, limit2_code[2*g+:2],
               limit1_code[2*g+:2], above_range[g], below_range[g]});
         end
         if (full_select[g] || value_select[g]) begin
            exp_q.push_back({1'h0, sample_value[16*g+:16]});
         end
      end
      if (exp_q.size() > first) begin
         exp_q[$][16] = 1'h1;
      end
      @(negedge clk);
      image_start = 1'h1;
      @(negedge clk);
      image_start = 1'h0;
   endtask : start_image

   task automatic compare_img();
      repeat (30) @(negedge clk);
      check("img_count", 32'(exp_q.size()), 32'(u_master.got.size()));
      for (int i = 0; i < exp_q.size() && i < u_master.got.size(); i++) begin
         check("img_word", {15'h0, exp_q[i]}, {15'h0, u_master.got[i]});
      end
      exp_q.delete();
      u_master.got.delete();
   endtask : compare_img

   // Hang guard.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("[ERR] run_time expected end seen timeout");
      end_sim();
   end

   // Main sequence.
   initial begin
      {rst_n, image_start, stall, slow, obj_req, sample_strobe, below_range, above_range} = '0;
      {sample_invalid, full_select, value_select, sample_value, limit1_code, limit2_code} = '0;
      {obj_index, obj_subindex, tog, bad_count, cmp_count} = '0;
      backup_entries = {32'h0000_0001, 32'h1234_5678, 32'h0000_0020, 32'hFFFF_FFF0};
      repeat (6) @(negedge clk);
      check("reset_idle", 32'h0000_0000, {29'h0, obj_ack, img_valid, image_busy});
      rst_n = 1'h1;
      foreach (rows[i]) begin
         obj_read(rows[i].idx, rows[i].sub, rows[i].dat, rows[i].err);
      end
      for (int k = 0; k < 2; k++) begin
         sum = '0;
         for (int w = 0; w < 4; w++) sum = sum + backup_entries[32*w+:32];
         obj_read(16'h10F0, 8'h01, sum, 1'h0);
         backup_entries[63:32] = 32'h8000_0003;
      end
      for (int g = 0; g < 4; g++) begin
         sample_value[16*g+:16] = 16'h8000 + 16'(g * 16'h1111);
         below_range[g] = (g == 1);
         above_range[g] = (g == 2);
         limit1_code[2*g+:2] = 2'(g);
         limit2_code[2*g+:2] = 2'(3 - g);
         sample_invalid[g] = (g == 3);
      end
      strobe_all();
      full_select = 4'h5;
      value_select = 4'h6;
      #1 check("layout_conflict", 32'h0000_0004, {28'h0, layout_conflict});
      slow = 1'h1;
      start_image();
      wait_idle();
      {full_select, value_select} = '0;
      start_image();
      wait_idle();
      compare_img();
      strobe_all();
      {slow, stall, full_select} = {1'h0, 1'h1, 4'hF};
      for (int k = 0; k < 3; k++) begin
         start_image();
         if (k < 2) wait_idle();
      end
      repeat (20) @(negedge clk);
      check("fifo_full_stall", 32'h0000_0003, {30'h0, image_busy, img_valid});
      stall = 1'h0;
      wait_idle();
      compare_img();
      end_sim();
   end
endmodule : aipk_packer_test
